// *** ssp_map.vh ***
// register map, field positions, reset values and timing counts of the serial port
`ifndef SSP_MAP_VH
`define SSP_MAP_VH
// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define SSP_OFS_BUF   8'h00
`define SSP_OFS_CTL1  8'h04
`define SSP_OFS_CTL2  8'h08
`define SSP_OFS_STAT  8'h0C
`define SSP_OFS_OWNID 8'h10
`define SSP_OFS_EVT   8'h14
// ---------------------------------------------------------------
// control one fields
// ---------------------------------------------------------------
`define SSP_C1_WCOL   7
`define SSP_C1_OV     6
`define SSP_C1_EN     5
`define SSP_C1_CKP    4
// ---------------------------------------------------------------
// status fields
// ---------------------------------------------------------------
`define SSP_ST_SMP    7
`define SSP_ST_CKE    6
// ---------------------------------------------------------------
// event register fields
// ---------------------------------------------------------------
`define SSP_EV_FLAG   0
`define SSP_EV_IE     1
`define SSP_EV_BUSY   2
// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define SSP_RST_BYTE  8'h00
// ---------------------------------------------------------------
// mode codes
// ---------------------------------------------------------------
`define SSP_M_TMR     4'h3
`define SSP_M_SSCTL   4'h4
`define SSP_M_SSFREE  4'h5
`define SSP_M_I2C_LO  4'h6
`define SSP_M_I2C_T10 4'h7
`define SSP_M_I2C_MST 4'h8
`define SSP_M_I2C_FW  4'hB
`define SSP_M_I2C_T10I 4'hF
// ---------------------------------------------------------------
// master clock half periods in system clocks
// ---------------------------------------------------------------
`define SSP_HALF_D4   6'h02
`define SSP_HALF_D16  6'h08
`define SSP_HALF_D64  6'h20
`endif

// *** ssp_port.v ***
// serial port: wishbone registers, spi shift engine, i2c status and control set
//
// Behaviour
// [R01] slave with select control: shift and drive data out only while select low
// [R02] select rising stops driving data out at once, even mid byte
// [R03] mode 0100 holds spi shift logic in reset while select is high
// [R04] spi reset clears bit counter; select high or enable clear cause it
// [R05] software enables select control when slave mode uses edge select set
// [R06] master mode sleep freezes the transfer; it resumes on run
// [R07] master transfer completion can wake the device when enabled
// [R08] slave shifts on external clock in any power state; 8 bits set flag
// [R09] device reset disables the port and aborts any transfer
// [R10] spi modes map to polarity and edge bits as tabled
// [R11] own id register: slave address, low seven bits master rate reload
// [R12] i2c received byte moves to buffer and sets the port flag
// [R13] i2c transmit write loads buffer and shift register together
// [R14] control registers read/write; status low six bits read only
// [R15] status bit 7 set disables slew control, clear enables it
// [R16] status bit 6 set enables smbus input thresholds
// [R17] slave status bit 5 tells data or address for last byte
// [R18] status bits 4 and 3 show stop or start last; clear on disable
// [R19] status bit 2: slave read/write of last match; master transmit busy
// [R20] read/write bit ored with request bits shows i2c busy
// [R21] ten bit slave sets bit 1 when own id needs reloading
// [R22] status bit 0 buffer full on receive, shifting on transmit
// [R23] polarity bit set idles clock high, clear idles low
// [R24] buffer read clears buffer full
//
// Design decisions made here: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`include "ssp_map.vh"
module ssp_port #(
   parameter BITS = 8
)(
   // clock and reset
   input  wire        clk_i,
   input  wire        rst_i,
   // wishbone slave
   input  wire        cyc_i,
   input  wire        stb_i,
   input  wire        we_i,
   input  wire [7:0]  adr_i,
   input  wire [3:0]  sel_i,
   input  wire [31:0] dat_i,
   output reg  [31:0] dat_o,
   output reg         ack_o,
   // spi pins
   input  wire        sck_i,
   input  wire        sdi_i,
   input  wire        ss_n_i,
   output reg         sck_o,
   output reg         sck_oe_o,
   output reg         sdo_o,
   output reg         sdo_oe_o,
   // power and timer
   input  wire        sleep_i,
   input  wire        timer_tick_i,
   output reg         wake_o,
   // i2c sequencer events
   input  wire        i2c_start_i,
   input  wire        i2c_stop_i,
   input  wire        i2c_nack_i,
   input  wire        i2c_addr_i,
   input  wire        i2c_rw_i,
   input  wire        i2c_rx_i,
   input  wire [7:0]  i2c_rx_byte_i,
   input  wire        i2c_tx_done_i,
   input  wire        i2c_tx_busy_i,
   input  wire [4:0]  i2c_req_done_i,
   // i2c sequencer controls
   output reg  [7:0]  i2c_tx_byte_o,
   output reg  [4:0]  i2c_req_o,
   output reg  [7:0]  own_addr_o,
   output reg  [6:0]  rate_reload_o,
   output reg         slew_ctl_o,
   output reg         smbus_lvl_o
);

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function [5:0] ssp_half;
      input [3:0] m;
      begin
         if (m == 4'h0)
            ssp_half = `SSP_HALF_D4;
         else if (m == 4'h1)
            ssp_half = `SSP_HALF_D16;
         else
            ssp_half = `SSP_HALF_D64;
      end
   endfunction

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   reg [7:0]  buf_q;
   reg [7:0]  ctl1_q;
   reg [7:0]  ctl2_q;
   reg [1:0]  stat_hi_q;
   reg [7:0]  own_q;
   reg        flag_q;
   reg        ie_q;
   reg        bf_q;
   reg        da_q;
   reg        stop_q;
   reg        start_q;
   reg        rw_q;
   reg        ua_q;
   reg [7:0]  sr_q;
   reg [3:0]  cnt_q;
   reg        smp_q;
   reg        m_act_q;
   reg        m_ph_q;
   reg [5:0]  div_q;
   reg [1:0]  sck_sy_q;
   reg [1:0]  sdi_sy_q;
   reg [1:0]  ss_sy_q;
   reg        sck_prev_q;

   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   wire [3:0] mode   = ctl1_q[3:0];
   wire       en     = ctl1_q[`SSP_C1_EN];
   wire       clock_polarity    = ctl1_q[`SSP_C1_CKP];
   wire       sample_phase    = stat_hi_q[1];
   wire       cke    = stat_hi_q[0];
   wire       mst    = en & (mode <= `SSP_M_TMR);
   wire       slv    = en & ((mode == `SSP_M_SSCTL) | (mode == `SSP_M_SSFREE));
   wire       i2c    = en & (mode >= `SSP_M_I2C_LO);
   wire       i2c_m  = i2c & ((mode == `SSP_M_I2C_MST) | (mode == `SSP_M_I2C_FW));
   wire       ten    = (mode == `SSP_M_I2C_T10) | (mode == `SSP_M_I2C_T10I);
   wire       sck_s  = sck_sy_q[1];
   wire       sdi_s  = sdi_sy_q[1];
   wire       ss_s   = ss_sy_q[1];
   // [R03] select-high reset
   wire       spi_rst = ~(mst | slv) | ((mode == `SSP_M_SSCTL) & ss_s);

   // bus strobes, effects land on the ack edge
   wire       acc    = cyc_i & stb_i & ~ack_o;
   wire       wr     = acc & we_i & sel_i[0];
   wire       rd     = acc & ~we_i;
   wire       wr_buf = wr & (adr_i == `SSP_OFS_BUF);
   wire       wr_c1  = wr & (adr_i == `SSP_OFS_CTL1);
   wire       wr_c2  = wr & (adr_i == `SSP_OFS_CTL2);
   wire       wr_st  = wr & (adr_i == `SSP_OFS_STAT);
   wire       wr_own = wr & (adr_i == `SSP_OFS_OWNID);
   wire       wr_ev  = wr & (adr_i == `SSP_OFS_EVT);
   wire       rd_buf = rd & (adr_i == `SSP_OFS_BUF);

   // [R19] slave match bit or master transmit busy
   wire       rw_rd  = i2c_m ? i2c_tx_busy_i : rw_q;
   // [R20] busy is the or of rw and requests
   wire       i2c_busy = rw_rd | (|ctl2_q[4:0]);
   wire       spi_busy = (cnt_q != 4'h0) | m_act_q;
   wire       buf_ok = wr_buf & (i2c ? ~i2c_busy : ~spi_busy);

   // [R10] [R23] leading edge leaves idle level set by polarity
   wire       s_lead = slv & (sck_s != clock_polarity) & (sck_prev_q == clock_polarity);
   wire       s_trail = slv & (sck_s == clock_polarity) & (sck_prev_q != clock_polarity);
   // [R06] master ticks stop while sleeping
   wire       tick = m_act_q & ~sleep_i &
                     ((mode == `SSP_M_TMR) ? timer_tick_i : (div_q == ssp_half(mode) - 6'h01));
   wire       lead  = s_lead | (tick & ~m_ph_q);
   wire       trail = s_trail | (tick & m_ph_q);
   wire       bit_in = (cke & ~(mst & sample_phase)) ? smp_q : sdi_s;
   wire       done  = trail & (cnt_q == 4'h7) & ~spi_rst;

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         sck_sy_q   <= 2'b00;
         sdi_sy_q   <= 2'b00;
         ss_sy_q    <= 2'b11;
         sck_prev_q <= 1'b0;
      end else begin
         sck_sy_q   <= {sck_sy_q[0], sck_i};
         sdi_sy_q   <= {sdi_sy_q[0], sdi_i};
         ss_sy_q    <= {ss_sy_q[0], ss_n_i};
         sck_prev_q <= sck_s;
      end
   end

   // ---------------------------------------------------------------
   // master clock generator
   // ---------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i | ~mst) begin
         m_act_q <= 1'b0;
         m_ph_q  <= 1'b0;
         div_q   <= 6'h00;
      end else begin
         if (buf_ok)
            m_act_q <= 1'b1;
         else if (done)
            m_act_q <= 1'b0;
         if (tick) begin
            div_q  <= 6'h00;
            m_ph_q <= ~m_ph_q;
         end else if (m_act_q & ~sleep_i & (mode != `SSP_M_TMR)) begin
            div_q  <= div_q + 6'h01;
         end
      end
   end

   // ---------------------------------------------------------------
   // shift register and bit counter
   // ---------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         // [R09] reset aborts the transfer
         sr_q  <= `SSP_RST_BYTE;
         cnt_q <= 4'h0;
         smp_q <= 1'b0;
      end else if (buf_ok) begin
         // [R13] write fills shift register too
         sr_q  <= dat_i[7:0];
         cnt_q <= 4'h0;
      end else if (spi_rst) begin
         // [R04] counter forced to zero
         cnt_q <= 4'h0;
      end else begin
         // [R08] slave runs on external clock edges
         if (lead)
            smp_q <= sdi_s;
         if (trail) begin
            sr_q  <= {sr_q[6:0], bit_in};
            cnt_q <= (cnt_q == 4'h7) ? 4'h0 : cnt_q + 4'h1;
         end
      end
   end

   // ---------------------------------------------------------------
   // buffer, buffer full and overflow
   // ---------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         buf_q <= `SSP_RST_BYTE;
         bf_q  <= 1'b0;
      end else begin
         // [R24] read clears full
         if (rd_buf | (i2c & i2c_tx_done_i))
            bf_q <= 1'b0;
         if (buf_ok) begin
            buf_q <= dat_i[7:0];
            // [R22] full while transmit shifts
            if (i2c)
               bf_q <= 1'b1;
         end else if (done & ~(slv & bf_q)) begin
            buf_q <= {sr_q[6:0], bit_in};
            bf_q  <= 1'b1;
         end else if (i2c & i2c_rx_i & ~bf_q & ~ctl1_q[`SSP_C1_OV]) begin
            // [R12] received byte moves to buffer
            buf_q <= i2c_rx_byte_i;
            bf_q  <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // control one: collision and overflow set wins over write
   // ---------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         ctl1_q <= `SSP_RST_BYTE;
      end else begin
         // [R14] fully writable
         if (wr_c1)
            ctl1_q <= dat_i[7:0];
         if (wr_buf & ~buf_ok)
            ctl1_q[`SSP_C1_WCOL] <= 1'b1;
         if ((done & slv & bf_q) | (i2c & i2c_rx_i & bf_q))
            ctl1_q[`SSP_C1_OV] <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // control two: requests set only when idle, cleared when done
   // ---------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i | ~i2c) begin
         ctl2_q <= `SSP_RST_BYTE;
      end else begin
         ctl2_q[4:0] <= ctl2_q[4:0] & ~i2c_req_done_i;
         if (wr_c2) begin
            ctl2_q[7:5] <= dat_i[7:5];
            if (~i2c_busy)
               ctl2_q[4:0] <= dat_i[4:0];
         end
      end
   end

   // ---------------------------------------------------------------
   // status, own id and event registers
   // ---------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         stat_hi_q <= 2'b00;
         own_q     <= `SSP_RST_BYTE;
         ie_q      <= 1'b0;
      end else begin
         // [R14] only upper two status bits writable
         if (wr_st)
            stat_hi_q <= dat_i[7:6];
         if (wr_own)
            own_q <= dat_i[7:0];
         if (wr_ev)
            ie_q <= dat_i[`SSP_EV_IE];
      end
   end

   // i2c bus event flags
   always @(posedge clk_i) begin
      if (rst_i | ~i2c) begin
         // [R18] cleared on reset and disable
         start_q <= 1'b0;
         stop_q  <= 1'b0;
         da_q    <= 1'b0;
         rw_q    <= 1'b0;
         ua_q    <= 1'b0;
      end else begin
         // [R18] most recent of start and stop
         if (i2c_start_i) begin
            start_q <= 1'b1;
            stop_q  <= 1'b0;
         end else if (i2c_stop_i) begin
            start_q <= 1'b0;
            stop_q  <= 1'b1;
         end
         // [R17] data or address of last byte
         if ((i2c_rx_i | i2c_tx_done_i) & ~i2c_m)
            da_q <= ~i2c_addr_i;
         // [R19] match bit valid to start, stop or nack
         if (i2c_addr_i)
            rw_q <= i2c_rw_i;
         else if (i2c_start_i | i2c_stop_i | i2c_nack_i)
            rw_q <= 1'b0;
         // [R21] ten bit slave asks for id reload
         if (wr_own)
            ua_q <= 1'b0;
         if (i2c_addr_i & ten & ~i2c_m)
            ua_q <= 1'b1;
      end
   end

   // port flag: write one clears, event set wins
   always @(posedge clk_i) begin
      if (rst_i) begin
         flag_q <= 1'b0;
      end else begin
         if (wr_ev & dat_i[`SSP_EV_FLAG])
            flag_q <= 1'b0;
         // [R08] [R12] byte completion sets flag
         if (done | (i2c & (i2c_rx_i | i2c_start_i | i2c_stop_i)))
            flag_q <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // wishbone answer, one wait state
   // ---------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h00000000;
      end else begin
         ack_o <= acc;
         dat_o <= 32'h00000000;
         if (rd) begin
            if (adr_i == `SSP_OFS_BUF)
               dat_o[7:0] <= buf_q;
            else if (adr_i == `SSP_OFS_CTL1)
               dat_o[7:0] <= ctl1_q;
            else if (adr_i == `SSP_OFS_CTL2)
               dat_o[7:0] <= ctl2_q;
            else if (adr_i == `SSP_OFS_STAT)
               dat_o[7:0] <= {stat_hi_q, da_q, stop_q, start_q, rw_rd, ua_q, bf_q};
            else if (adr_i == `SSP_OFS_OWNID)
               dat_o[7:0] <= own_q;
            else if (adr_i == `SSP_OFS_EVT)
               dat_o[2:0] <= {i2c_busy, ie_q, flag_q};
         end
      end
   end

   // ---------------------------------------------------------------
   // registered pin and side outputs
   // ---------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         sck_o         <= 1'b0;
         sck_oe_o      <= 1'b0;
         sdo_o         <= 1'b0;
         sdo_oe_o      <= 1'b0;
         wake_o        <= 1'b0;
         i2c_tx_byte_o <= `SSP_RST_BYTE;
         i2c_req_o     <= 5'h00;
         own_addr_o    <= `SSP_RST_BYTE;
         rate_reload_o <= 7'h00;
         slew_ctl_o    <= 1'b0;
         smbus_lvl_o   <= 1'b0;
      end else begin
         // [R23] idle level follows polarity
         sck_o    <= m_ph_q ^ clock_polarity;
         sck_oe_o <= mst;
         sdo_o    <= sr_q[7];
         // [R01] [R02] in mode 0100 drive only while select low
         sdo_oe_o <= mst | (slv & ~((mode == `SSP_M_SSCTL) & ss_s));
         // [R07] completion wakes when enabled
         wake_o   <= flag_q & ie_q;
         i2c_tx_byte_o <= sr_q;
         i2c_req_o     <= ctl2_q[4:0];
         // [R11] slave address or master rate reload
         own_addr_o    <= (i2c & ~i2c_m) ? own_q : `SSP_RST_BYTE;
         rate_reload_o <= i2c_m ? own_q[6:0] : 7'h00;
         // [R15] [R16] i2c pad controls
         slew_ctl_o    <= i2c & ~sample_phase;
         smbus_lvl_o   <= i2c & cke;
      end
   end

endmodule

// *** ssp_chk_sva.sv ***
// assertion checker for the serial port bus, pins and i2c controls
`timescale 1ns/1ps
module ssp_chk #(
   parameter BITS = 8
)(
   // clock, reset and bus
   input wire        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o,
   input wire [7:0]  adr_i,
   input wire [3:0]  sel_i,
   input wire [31:0] dat_i,
   // pins and controls
   input wire        ss_n_i, sleep_i, sck_o, sck_oe_o, sdo_oe_o, wake_o,
   input wire        slew_ctl_o, smbus_lvl_o,
   input wire [7:0]  own_addr_o,
   input wire [4:0]  i2c_req_o,
   input wire [6:0]  rate_reload_o
);
   logic [7:0] c1_q, st_q, id_q;
   logic       ie_q, sck_l_q;
   logic [5:0] age_q, idle_q;
   wire        take = cyc_i & stb_i & ~ack_o;
   wire        wr = take & we_i & sel_i[0];
   wire        m4 = c1_q[5] & (c1_q[3:0] == 4'h4);
   wire        mst = c1_q[5] & (c1_q[3:0] < 4'h3);
   wire        i2c = c1_q[5] & (c1_q[3:0] == 4'h6 || c1_q[3:0] == 4'h8);
   // mirror of software written fields and quiet-time counters
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         {c1_q, st_q, id_q, ie_q, sck_l_q} <= '0;
         age_q <= 6'h00;
         idle_q <= 6'h00;
      end else begin
         sck_l_q <= sck_o;
         age_q <= wr ? 6'h00 : age_q + {5'h00, age_q != 6'h3F};
         idle_q <= (wr || sck_o != sck_l_q) ? 6'h00 : idle_q + {5'h00, idle_q != 6'h3F};
         if (wr && adr_i == 8'h04) c1_q <= dat_i[7:0];
         if (wr && adr_i == 8'h0C) st_q <= dat_i[7:0];
         if (wr && adr_i == 8'h10) id_q <= dat_i[7:0];
         if (wr && adr_i == 8'h14) ie_q <= dat_i[1];
      end
   end
   // ----------------------------------------
   // properties
   // ----------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_ack_once: assert property (take |=> ack_o ##1 !ack_o)
      else $error("bus ack not a single pulse after request");
   a_sdo_float: assert property ((m4 && ss_n_i)[*5] |-> !sdo_oe_o)
      else $error("data out still driven with select high");
   a_sdo_drive: assert property ((m4 && !ss_n_i)[*5] |-> sdo_oe_o)
      else $error("data out not driven with select low");
   a_sck_idle: assert property (mst && idle_q >= 6'd40 |-> sck_o == c1_q[4])
      else $error("master clock not at polarity level when idle");
   a_wake_gated: assert property (!ie_q && !$past(ie_q) |-> !wake_o)
      else $error("wake raised with interrupt disabled");
   a_slew_map: assert property (i2c && age_q >= 6'd2 |-> slew_ctl_o == !st_q[7])
      else $error("slew control does not follow status bit 7");
   a_smbus_map: assert property (i2c && age_q >= 6'd2 |-> smbus_lvl_o == st_q[6])
      else $error("smbus levels do not follow status bit 6");
   a_rate_copy: assert property (c1_q[5] && c1_q[3:0] == 4'h8 && age_q >= 6'd2
      |-> rate_reload_o == id_q[6:0])
      else $error("rate reload differs from own id low bits");
   a_own_copy: assert property (c1_q[5] && c1_q[3:0] == 4'h6 && age_q >= 6'd2
      |-> own_addr_o == id_q)
      else $error("own address differs from own id register");
   a_rst_quiet: assert property ($fell(rst_i) |-> !sdo_oe_o && !sck_oe_o && i2c_req_o == 5'h00)
      else $error("port active right after reset");
   c_abort: cover property (m4 && !ss_n_i ##1 ss_n_i);
   c_wake: cover property ($rose(wake_o));
   c_sleep: cover property (sck_oe_o && sleep_i);
endmodule
bind ssp_port ssp_chk #(.BITS(BITS)) u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
   .we_i(we_i), .ack_o(ack_o), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .ss_n_i(ss_n_i),
   .sleep_i(sleep_i), .sck_o(sck_o), .sck_oe_o(sck_oe_o), .sdo_oe_o(sdo_oe_o), .wake_o(wake_o),
   .slew_ctl_o(slew_ctl_o), .smbus_lvl_o(smbus_lvl_o), .own_addr_o(own_addr_o),
   .i2c_req_o(i2c_req_o), .rate_reload_o(rate_reload_o));

// *** ssp_far.sv ***
// far side spi master model driving the slave pins
`timescale 1ns/1ps
module ssp_far #(
   parameter int H = 8
)(
   input  wire  clk_i,
   input  wire  sdo_i,
   input  wire  sdo_oe_i,
   output logic sck_o,
   output logic sdi_o,
   output logic ss_n_o
);
   initial begin
      sck_o = 1'b0;
      sdi_o = 1'b0;
      ss_n_o = 1'b1;
   end
   // one frame of nb bits, msb first, clock still outside the frame
   task automatic xfer(input logic [7:0] tx, input int nb, input logic cpol, cpha, output logic [7:0] rx);
      int i;
      begin
         rx = 8'h00;
         @(posedge clk_i);
         sck_o <= cpol;
         repeat (H) @(posedge clk_i);
         ss_n_o <= 1'b0;
         for (i = 7; i > 7 - nb; i--) begin
            if (!cpha) sdi_o <= tx[i];
            repeat (H) @(posedge clk_i);
            sck_o <= ~cpol;
            if (cpha) sdi_o <= tx[i];
            else rx[i] = sdo_oe_i ? sdo_i : 1'bx;
            repeat (H) @(posedge clk_i);
            sck_o <= cpol;
            if (cpha) rx[i] = sdo_oe_i ? sdo_i : 1'bx;
         end
         repeat (H) @(posedge clk_i);
         ss_n_o <= 1'b1;
         sdi_o <= ~sdi_o;
      end
   endtask
endmodule

// *** ssp_port_tb.sv ***
// self-checking bench for the serial port
`timescale 1ns/1ps
module ssp_port_tb;
   logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, sleep_i = 1'b0;
   logic        timer_tick_i = 1'b0, i2c_start_i = 1'b0, i2c_stop_i = 1'b0, i2c_nack_i = 1'b0;
   logic        i2c_addr_i = 1'b0, i2c_rw_i = 1'b0, i2c_rx_i = 1'b0, i2c_tx_done_i = 1'b0;
   logic        i2c_tx_busy_i = 1'b0, lb = 1'b0, clock_polarity, cke, s;
   logic [7:0]  adr_i = '0, i2c_rx_byte_i = '0, d, tx, rx, got, id;
   logic [3:0]  sel_i = '0;
   logic [31:0] dat_i = '0;
   logic [4:0]  i2c_req_done_i = '0;
   logic [7:0]  q[$];
   int          i, n, cyc_n, n_errors, samples_checked;
   wire         sck_i, ss_n_i, far_sdi, ack_o, sck_o, sck_oe_o, sdo_o, sdo_oe_o, wake_o;
   wire         slew_ctl_o, smbus_lvl_o;
   wire [31:0]  dat_o;
   wire [7:0]   i2c_tx_byte_o, own_addr_o;
   wire [4:0]   i2c_req_o;
   wire [6:0]   rate_reload_o;
   // loopback joins data out to data in for master runs
   wire         sdi_w = lb ? sdo_o : far_sdi;
   ssp_port #(.BITS(8)) DUT (.*, .sdi_i(sdi_w));
   ssp_far far (.clk_i(clk_i), .sdo_i(sdo_o), .sdo_oe_i(sdo_oe_o), .sck_o(sck_i), .sdi_o(far_sdi), .ss_n_o(ss_n_i));
   initial begin
      forever #50 clk_i = ~clk_i;
   end
   // ----------------------------------------
   // bus, compare and report tasks
   // ----------------------------------------
   task wb(input logic [7:0] a, input logic w, input logic [7:0] wd, output logic [7:0] r);
      int k;
      begin
         k = 0;
         @(posedge clk_i);
         {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'b11, w, a, 4'hF, 24'h0, wd};
         do begin
            @(posedge clk_i);
            k++;
         end while (ack_o !== 1'b1 && k < 20);
         r = dat_o[7:0];
         {cyc_i, stb_i} <= 2'b00;
         if (k == 20) begin
            n_errors++;
            $display("[ERR] %0t bus ack missing", $time);
         end
      end
   endtask
   task chk(input logic [7:0] g, e);
      samples_checked++;
      if (g !== e) begin
         n_errors++;
         $display("[ERR] %0t got %h expected %h", $time, g, e);
      end
   endtask
   task wr(input logic [7:0] a, wd);
      logic [7:0] r;
      wb(a, 1'b1, wd, r);
   endtask
   task rc(input logic [7:0] a, e);
      logic [7:0] r;
      begin
         wb(a, 1'b0, 8'h00, r);
         chk(r, e);
      end
   endtask
   task ev(input logic [3:0] v);
      @(posedge clk_i) {i2c_start_i, i2c_stop_i, i2c_addr_i, i2c_rx_i} <= v;
      @(posedge clk_i) {i2c_start_i, i2c_stop_i, i2c_addr_i, i2c_rx_i} <= 4'h0;
   endtask
   task tend(input string t);
      $display("test %s done, errors %0d", t, n_errors);
   endtask
   task report_and_stop;
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // cycle budget guard against a hung run
   always @(posedge clk_i) begin
      cyc_n <= cyc_n + 1;
      if (cyc_n == 20000) begin
         n_errors++;
         report_and_stop;
      end
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      void'($urandom(32'h4EB6));
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      for (i = 0; i < 7; i++) rc(8'(i * 4), 8'h00);
      wr(8'h0C, 8'hFF);
      rc(8'h0C, 8'hC0);
      d = 8'($urandom) & 8'hDF;
      wr(8'h04, d);
      rc(8'h04, d);
      wr(8'h04, 8'h28);
      d = 8'($urandom);
      wr(8'h08, d);
      rc(8'h08, d);
      chk(8'(i2c_req_o), 8'(d[4:0]));
      @(posedge clk_i) i2c_req_done_i <= 5'h1F;
      @(posedge clk_i) i2c_req_done_i <= 5'h00;
      repeat (2) @(posedge clk_i);
      chk(8'(i2c_req_o), 8'h00);
      wr(8'h04, 8'h00);
      tend("registers");
      for (i = 0; i < 4; i++) begin
         clock_polarity = i[1];
         cke = ~i[0];
         // select control always on in slave mode
         wr(8'h04, {3'h1, clock_polarity, 4'h4});
         wr(8'h0C, {1'b0, cke, 6'h00});
         tx = 8'($urandom);
         rx = 8'($urandom);
         q.push_back(rx);
         wr(8'h00, tx);
         far.xfer(rx, 8, i[1], i[0], got);
         chk(got, tx);
         repeat (8) @(posedge clk_i);
         rc(8'h0C, {1'b0, cke, 6'h01});
         rc(8'h14, 8'h01);
         rc(8'h00, q.pop_front());
         rc(8'h0C, {1'b0, cke, 6'h00});
         wr(8'h14, 8'h01);
      end
      tend("slave modes");
      wr(8'h04, 8'h24);
      wr(8'h0C, 8'h40);
      wr(8'h00, 8'($urandom));
      far.xfer(8'($urandom), 4, 1'b0, 1'b0, got);
      repeat (5) @(posedge clk_i);
      chk(8'(sdo_oe_o), 8'h00);
      rc(8'h0C, 8'h40);
      rx = 8'($urandom);
      far.xfer(rx, 8, 1'b0, 1'b0, got);
      repeat (8) @(posedge clk_i);
      rc(8'h00, rx);
      wr(8'h14, 8'h01);
      tend("abort");
      lb <= 1'b1;
      wr(8'h0C, 8'h00);
      wr(8'h14, 8'h02);
      wr(8'h04, 8'h21);
      tx = 8'($urandom);
      wr(8'h00, tx);
      repeat (40) @(posedge clk_i);
      sleep_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      s = sck_o;
      n = 0;
      repeat (25) begin
         @(posedge clk_i);
         n += (sck_o !== s);
      end
      chk(8'(n), 8'h00);
      sleep_i <= 1'b0;
      n = 0;
      while (wake_o !== 1'b1 && n < 400) begin
         @(posedge clk_i);
         n++;
      end
      chk(8'(wake_o), 8'h01);
      rc(8'h00, tx);
      wr(8'h14, 8'h01);
      repeat (50) @(posedge clk_i);
      lb <= 1'b0;
      tend("master sleep");
      id = 8'($urandom);
      wr(8'h10, id);
      wr(8'h04, 8'h26);
      wr(8'h0C, 8'h40);
      repeat (3) @(posedge clk_i);
      chk(own_addr_o, id);
      chk({6'h00, slew_ctl_o, smbus_lvl_o}, 8'h03);
      i2c_rw_i <= 1'b1;
      ev(4'h8);
      rc(8'h0C, 8'h48);
      ev(4'h2);
      rc(8'h0C, 8'h4C);
      rx = 8'($urandom);
      i2c_rx_byte_i <= rx;
      ev(4'h1);
      rc(8'h0C, 8'h6D);
      rc(8'h00, rx);
      ev(4'h4);
      wb(8'h0C, 1'b0, 8'h00, got);
      chk(got & 8'h18, 8'h10);
      wr(8'h04, 8'h28);
      tx = 8'($urandom);
      wr(8'h00, tx);
      repeat (2) @(posedge clk_i);
      chk(i2c_tx_byte_o, tx);
      chk({1'b0, rate_reload_o}, {1'b0, id[6:0]});
      wr(8'h04, 8'h08);
      wb(8'h0C, 1'b0, 8'h00, got);
      chk(got & 8'h18, 8'h00);
      tend("i2c");
      report_and_stop;
   end
endmodule
